// ---- dv/rlyd_host.sv ----
// Host model: serial bus master for the relay driver
`timescale 1ns/1ps
module rlyd_host
(
   // Link wires
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial
   begin
      cs_n = 1'h1;
      sclk = 1'h0;
      din  = 1'h0;
   end
   // Select, then wait out the select-to-clock setup
   task open();
      cs_n = 1'h0;
      #100;
   endtask : open
   // Bit 7 first; clock only runs inside a frame
   task send(input logic [7:0] w);
      for (int i = 7; i >= 0; i--)
      begin
         din = w[i];
         #3 sclk = 1'h1;
         #3 sclk = 1'h0;
      end
   endtask : send
   // Released data line flips so a stale bit never looks valid
   task close();
      #100 cs_n = 1'h1;
      din = ~din;
      #100;
   endtask : close
endmodule : rlyd_host

// ---- dv/rlyd_monitor.sv ----
// Port checker for the relay driver control block
`timescale 1ns/1ps
module rlyd_monitor
(
   // Clocks and reset
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       sclk,
   // Pins
   input wire logic       cs_n,
   input wire logic       din,
   input wire logic       dout,
   input wire logic       par_mode,
   input wire logic       out_sel_bit0,
   input wire logic       out_sel_bit1,
   input wire logic       out_sel_bit2,
   input wire logic       level_select,
   input wire logic       set_pin_n,
   input wire logic       clr_pin_n,
   input wire logic [7:0] relay_o,
   input wire logic [7:0] relay_oe_n
);
   // ---------------
   // Reference logic
   // ---------------
   logic [7:0] hist_q;
   logic [7:0] exp_par;
   wire        quiet = set_pin_n && clr_pin_n && cs_n;
   // Async like the pins, else a short set pulse is missed
   always_ff @(posedge sclk or negedge rst_n or negedge clr_pin_n
               or negedge set_pin_n)
      if (!rst_n || !clr_pin_n)
         hist_q <= 8'h00;
      else if (!set_pin_n)
         hist_q <= 8'hff;
      else if (!cs_n)
         hist_q <= {hist_q[6:0], din};
   always_comb
   begin
      exp_par = relay_oe_n;
      exp_par[{out_sel_bit2, out_sel_bit1, out_sel_bit0}] = !level_select;
   end
   // ----------
   // Properties
   // ----------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rst; $rose(rst_n) |-> (relay_oe_n == 8'hff) [*2]; endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not off after reset");
   // Pin sampled, two sync stages, latch, output flop: fifth sample
   property p_clr; !clr_pin_n [*5] |-> relay_oe_n == 8'hff && !dout;
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear did not turn outputs off");
   property p_both; (!clr_pin_n && !set_pin_n) [*5] |-> relay_oe_n == 8'hff;
   endproperty
   a_both: assert property (p_both)
      else $error("set beat clear");
   property p_set; (!set_pin_n && clr_pin_n) [*5] |-> relay_oe_n == 8'h00
      && dout;
   endproperty
   a_set: assert property (p_set)
      else $error("set did not turn outputs on");
   property p_sink; relay_o == 8'h00; endproperty
   a_sink: assert property (p_sink)
      else $error("output driven to wrong level");
   property p_dout; quiet |-> dout == hist_q[7]; endproperty
   a_dout: assert property (p_dout)
      else $error("serial out is not the last stage");
   property p_ser; $rose(cs_n) && !par_mode ##0 quiet [*8]
      |-> relay_oe_n == ~hist_q;
   endproperty
   a_ser: assert property (p_ser)
      else $error("serial word not latched");
   property p_par; $rose(cs_n) && par_mode ##0 quiet [*8]
      |-> relay_oe_n == $past(exp_par, 7);
   endproperty
   a_par: assert property (p_par)
      else $error("parallel update wrong");
   c_ser: cover property ($rose(cs_n) && !par_mode);
   c_par: cover property ($rose(cs_n) && par_mode);
   c_set: cover property (!set_pin_n && !clr_pin_n);
endmodule : rlyd_monitor
bind rlyd_top rlyd_monitor u_rlyd_monitor (.*);

// ---- dv/tb_relay_driver_serial_latch.sv ----
// Self-checking bench for the relay driver control block
`timescale 1ns/1ps
module tb_relay_driver_serial_latch;
   logic       mclk, rst_n, sclk, cs_n, din, dout, par_mode;
   logic       level_select, set_pin_n, clr_pin_n;
   logic [2:0] sel;
   logic [7:0] relay_o, relay_oe_n, exp_q;
   int         err_count, checks_done;

   rlyd_top u_rlyd_top (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .par_mode(par_mode),
      .out_sel_bit0(sel[0]), .out_sel_bit1(sel[1]), .out_sel_bit2(sel[2]),
      .level_select(level_select), .set_pin_n(set_pin_n),
      .clr_pin_n(clr_pin_n), .relay_o(relay_o), .relay_oe_n(relay_oe_n));
   rlyd_host u_rlyd_host (.cs_n(cs_n), .sclk(sclk), .din(din));

   initial
   begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   // -----
   // Tasks
   // -----
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // Update lands on the fifth edge after deselect; 8 leaves margin
   task frame(input logic [7:0] w);
      u_rlyd_host.open();
      u_rlyd_host.send(w);
      u_rlyd_host.close();
      cyc(8);
   endtask : frame
   task t_serial();
      logic [7:0] w [3];
      w = '{8'ha5, 8'h3c, 8'h80};
      chk("oe", relay_oe_n, 8'hff);
      for (int i = 0; i < 3; i++)
      begin
         frame(w[i]);
         chk("oe", relay_oe_n, ~w[i]);
         chk("dout", {7'h0, dout}, {7'h0, w[i][7]});
      end
      u_rlyd_host.open();
      u_rlyd_host.send(8'hff);
      u_rlyd_host.send(8'h81);
      u_rlyd_host.close();
      cyc(8);
      chk("oe", relay_oe_n, 8'h7e);
      $display("serial done");
   endtask : t_serial
   task t_par();
      exp_q = relay_oe_n;
      par_mode = 1'h1;
      cyc(4);
      for (int i = 0; i < 16; i++)
      begin
         sel = i[2:0];
         level_select = !i[3] || i[0];
         cyc(1);
         u_rlyd_host.open();
         u_rlyd_host.close();
         cyc(8);
         exp_q[i % 8] = !level_select;
         chk("oe", relay_oe_n, exp_q);
      end
      par_mode = 1'h0;
      $display("parallel done");
   endtask : t_par
   task t_setclr();
      set_pin_n = 1'h0;
      cyc(6);
      chk("oe", relay_oe_n, 8'h00);
      chk("sink", relay_o, 8'h00);
      chk("dout", {7'h0, dout}, 8'h01);
      clr_pin_n = 1'h0;
      cyc(6);
      chk("oe", relay_oe_n, 8'hff);
      chk("dout", {7'h0, dout}, 8'h00);
      set_pin_n = 1'h1;
      cyc(2);
      clr_pin_n = 1'h1;
      cyc(4);
      frame(8'h0f);
      chk("oe", relay_oe_n, 8'hf0);
      $display("set and clear done");
   endtask : t_setclr
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      err_count = 0;
      checks_done = 0;
      rst_n = 1'h1;
      par_mode = 1'h0;
      sel = 3'h0;
      level_select = 1'h0;
      set_pin_n = 1'h1;
      clr_pin_n = 1'h1;
      // A real falling edge, so the link-side async resets see it
      #1;
      rst_n = 1'h0;
      cyc(5);
      rst_n = 1'h1;
      cyc(3);
      t_serial();
      t_par();
      t_setclr();
      wrap_up();
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(negedge mclk);
      err_count++;
      wrap_up();
   end
endmodule : tb_relay_driver_serial_latch

// ---- verilog/rlyd_pkg.sv ----
// Constants and types shared by the relay driver control logic
package rlyd_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int NUM_OUT   = 8;
   localparam int ADDR_W    = 3;

   // ------------------------------------------------------------
   // Reset and forced values
   // ------------------------------------------------------------
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] LATCH_SET = 8'hff;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [7:0] SHIFT_SET = 8'hff;
   localparam logic       SINK_LVL  = 1'h0;

   // ------------------------------------------------------------
   // Chip select tracking states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SELECT = 2'b01,
      ST_UPDATE = 2'b10
   } rlyd_state_t;

endpackage : rlyd_pkg

// ---- verilog/rlyd_shift.sv ----
// Serial link shift register and daisy-chain output, link clock domain
`timescale 1ns/1ps
module rlyd_shift
   import rlyd_pkg::*;
(
   // Link clock and asynchronous controls
   input  wire logic         sclk,
   input  wire logic         clr_n,
   input  wire logic         set_n,
   // Serial link
   input  wire logic         cs_n,
   input  wire logic         din,
   output logic              dout,
   // Word to the core domain
   output logic [NUM_OUT-1:0] word
);

   logic [NUM_OUT-1:0] sr_q;
   logic               dout_q;

   // Clear beats set; shift only while selected
   always_ff @(posedge sclk or negedge clr_n or negedge set_n)
   begin
      if (!clr_n)
         sr_q <= SHIFT_RST;
      else if (!set_n)
         sr_q <= SHIFT_SET;
      else if (!cs_n)
         sr_q <= {sr_q[NUM_OUT-2:0], din};
   end

   // Last stage moves out on the falling edge
   always_ff @(negedge sclk or negedge clr_n or negedge set_n)
   begin
      if (!clr_n)
         dout_q <= SHIFT_RST[NUM_OUT-1];
      else if (!set_n)
         dout_q <= SHIFT_SET[NUM_OUT-1];
      else
         dout_q <= sr_q[NUM_OUT-1];
   end

   assign dout = dout_q;
   assign word = sr_q;

endmodule : rlyd_shift

// ---- verilog/rlyd_sync.sv ----
// Two-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module rlyd_sync
   import rlyd_pkg::*;
#(
   parameter int         W  = 1,
   parameter logic [W-1:0] RV = '0
)(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // Level in, level out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds the second stage only
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RV;
         sync_q <= RV;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : rlyd_sync

// ---- verilog/rlyd_top.sv ----
// Relay driver control: serial and parallel update of eight sink outputs
`timescale 1ns/1ps
module rlyd_top
   import rlyd_pkg::*;
(
   // Core clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // Serial link, link clock domain
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              din,
   output logic                   dout,
   // Parallel variant inputs
   input  wire logic              par_mode,
   input  wire logic              out_sel_bit0,
   input  wire logic              out_sel_bit1,
   input  wire logic              out_sel_bit2,
   input  wire logic              level_select,
   // Global set and clear pins
   input  wire logic              set_pin_n,
   input  wire logic              clr_pin_n,
   // Open-drain relay outputs
   output logic [NUM_OUT-1:0]     relay_o,
   output logic [NUM_OUT-1:0]     relay_oe_n
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   // Core state
   rlyd_state_t         state_q;
   rlyd_state_t         state_d;
   logic [NUM_OUT-1:0]  latch_q;
   logic [NUM_OUT-1:0]  latch_d;
   logic [NUM_OUT-1:0]  word_q;
   logic [ADDR_W-1:0]   addr_q;
   logic                lvl_q;
   logic [NUM_OUT-1:0]  oe_n_q;
   logic [NUM_OUT-1:0]  sink_q;

   // Link side
   logic [NUM_OUT-1:0]  link_word;
   logic                link_dout;
   logic                shift_clr_n;
   logic                shift_set_n;

   // Synchronised pins
   logic                cs_n_s;
   logic                par_mode_s;
   logic                set_n_s;
   logic                clr_n_s;
   logic [ADDR_W-1:0]   addr_s;
   logic                lvl_s;

   // Decode
   wire                 cs_rise;
   wire                 in_update;
   wire                 force_clr;
   wire                 force_set;
   wire [NUM_OUT-1:0]   par_mask;
   wire [NUM_OUT-1:0]   par_word;
   wire [NUM_OUT-1:0]   upd_word;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic [NUM_OUT-1:0] sel_decode(
      input logic [ADDR_W-1:0] a
   );
      logic [NUM_OUT-1:0] m;
      m    = '0;
      m[a] = 1'b1;
      return m;
   endfunction : sel_decode

   // ------------------------------------------------------------
   // Link domain shift register
   // ------------------------------------------------------------
   // Both pins act at once on the shift register, as they are
   // asynchronous by nature; clear is folded with core reset.
   // Core reset also clears the link side, as the clear pin does
   assign shift_clr_n = rst_n & clr_pin_n;
   assign shift_set_n = set_pin_n | ~clr_pin_n;

   rlyd_shift u_shift (
      .sclk  (sclk),
      .clr_n (shift_clr_n),
      .set_n (shift_set_n),
      .cs_n  (cs_n),
      .din   (din),
      .dout  (link_dout),
      .word  (link_word)
   );

   // Daisy-chain tap, already a link-domain flop
   assign dout = link_dout;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Deselected and inactive reset values avoid a false edge
   rlyd_sync #(
      .W  (1),
      .RV (1'h1)
   ) u_sync_cs (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i (cs_n),
      .sync_o  (cs_n_s)
   );

   rlyd_sync #(
      .W  (1),
      .RV (1'h0)
   ) u_sync_mode (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i (par_mode),
      .sync_o  (par_mode_s)
   );

   // ------------------------------------------------------------
   // Set and clear synchronisers
   // ------------------------------------------------------------
   // Latches see the pins two cycles late; the link side at once
   rlyd_sync #(
      .W  (2),
      .RV (2'h3)
   ) u_sync_sc (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i ({set_pin_n, clr_pin_n}),
      .sync_o  ({set_n_s, clr_n_s})
   );

   // ------------------------------------------------------------
   // Parallel input synchronisers
   // ------------------------------------------------------------
   // Address and level share the chip select latency
   rlyd_sync #(
      .W  (ADDR_W + 1),
      .RV (4'h0)
   ) u_sync_par (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i ({level_select, out_sel_bit2, out_sel_bit1,
                 out_sel_bit0}),
      .sync_o  ({lvl_s, addr_s})
   );

   // ------------------------------------------------------------
   // Chip select tracking
   // ------------------------------------------------------------
   // A select pulse under one cycle can be lost in the sync
   assign cs_rise   = (state_q == ST_SELECT) && cs_n_s;
   assign in_update = (state_q == ST_UPDATE);

   // Update lasts one cycle, so each rise applies once
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (!cs_n_s)
               state_d = ST_SELECT;
         end
         ST_SELECT:
         begin
            if (cs_n_s)
               state_d = ST_UPDATE;
         end
         ST_UPDATE:
         begin
            if (!cs_n_s)
               state_d = ST_SELECT;
            else
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // ------------------------------------------------------------
   // Update capture
   // ------------------------------------------------------------
   // The shift word is frozen once chip select is high, and the
   // synchronised edge arrives two cycles later, so it is stable.
   // Limitation: no link clock within four cycles of the rise.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_q <= LATCH_RST;
         addr_q <= '0;
         lvl_q  <= 1'b0;
      end
      else if (cs_rise)
      begin
         word_q <= link_word;
         addr_q <= addr_s;
         lvl_q  <= lvl_s;
      end
   end

   // ------------------------------------------------------------
   // Latch next value
   // ------------------------------------------------------------
   assign force_clr = !clr_n_s;
   assign force_set = !set_n_s && clr_n_s;

   // Parallel update touches only the addressed bit
   assign par_mask  = sel_decode(addr_q);
   assign par_word  = (latch_q & ~par_mask) |
                      (lvl_q ? par_mask : '0);

   // Bit n drives output n, bit 7 first on the wire
   assign upd_word  = par_mode_s ? par_word : word_q;

   // ------------------------------------------------------------
   // Latch select
   // ------------------------------------------------------------
   // Clear first, so it wins even over a pending update
   always_comb
   begin
      latch_d = latch_q;
      if (force_clr)
         latch_d = LATCH_RST;
      else if (force_set)
         latch_d = LATCH_SET;
      else if (in_update)
         latch_d = upd_word;
   end

   // ------------------------------------------------------------
   // Latch register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         latch_q <= LATCH_RST;
      else
         latch_q <= latch_d;
   end

   // ------------------------------------------------------------
   // Open-drain output stage
   // ------------------------------------------------------------
   // One cycle later than the latch so every output is a flop;
   // the delay is far below the relay turn-on time.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++)
      begin : g_out
         always_ff @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               oe_n_q[gi] <= 1'b1;
               sink_q[gi] <= SINK_LVL;
            end
            else
            begin
               oe_n_q[gi] <= ~latch_q[gi];
               sink_q[gi] <= SINK_LVL;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Output pins
   // ------------------------------------------------------------
   assign relay_oe_n = oe_n_q;
   // Value pin is fixed low; only the enable moves
   assign relay_o    = sink_q;

endmodule : rlyd_top
